// ===== rtl/otpp_cfg.svh
`ifndef OTPP_CFG_SVH
`define OTPP_CFG_SVH
// Overview of operation
// - Programmer enters: select low, init high-voltage pulse.
// - Entry sequence sets the programming-mode latch.
// - Programming mode repurposes all port pins.
// - Bytes shift in MSB first on data clock.
// - Shifting keeps high voltage and strobe high.
// - Low burn strobe writes the shifted byte.
// - Voltage pin low after burn selects read-back.
// - Strobe low plus clock loads output register.
// - Output bits advance on each clock rise.
// - Voltage pin steers clock to one register.
// - Address step strobe moves to next location.
// - Input register holds until overwritten.
// - Test decodes select stress test modes.
// - Protection bit blocks all read-back.
// - Serial input high during burn sets protection.
// - Protection allows later writes at any address.
// - Burning all ones adds protection, keeps data.

// Data byte width and the value of an unwritten location.
`define OTPP_BYTE_W 8
`define OTPP_ERASED 8'hff
// Default number of locations.
`define OTPP_DEPTH 256
// Burn pulse length in microseconds and system clock in MHz.
`define OTPP_BURN_US 100
`define OTPP_CLK_MHZ 200
// Programmer cycles per serial clock half period.
`define OTPP_HALF 8
// Depth of the programmer's byte queue.
`define OTPP_FIFO_DEPTH 16
`endif

// ===== rtl/otpp_device.sv
`timescale 1ns/1ps
`include "otpp_cfg.svh"
// Device end of the serial programming port. All pins come from the
// programmer's domain and are synchronised before any logic reads them.
module otpp_device #(
  parameter int DEPTH = `OTPP_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic arst_n,
  otpp_if.dev link,
  output logic prog_mode,
  output logic read_protected,
  output logic [AW-1:0] address,
  output logic [`OTPP_BYTE_W-1:0] last_burn,
  output otpp_pkg::otpp_stress_t stress_mode
);
  localparam int W = `OTPP_BYTE_W;
  localparam int NP = 9;

  // Raw pin bundle, in a fixed order for the synchroniser.
  logic [NP-1:0] pin_raw;
  // First synchroniser stage; read only by the second.
  logic [NP-1:0] sync1_reg;
  // Second synchroniser stage; the first stage any logic reads.
  logic [NP-1:0] sync2_reg;
  // Previous synchronised value for edge detection.
  logic [NP-1:0] prev_reg;

  assign pin_raw = {link.prog_select_pin, link.init_hv_pin,
                    link.address_step_pin, link.serial_clock_pin,
                    link.serial_in_pin, link.test_decode_a,
                    link.test_decode_b, link.program_voltage_pin,
                    link.burn_strobe_pin};

  // Two flip-flops per pin, then one more stage to find edges.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Named views of the synchronised pins.
  wire sel_s = sync2_reg[8];
  wire init_hv_s = sync2_reg[7];
  wire step_s = sync2_reg[6];
  wire sclk_s = sync2_reg[5];
  wire sin_s = sync2_reg[4];
  wire ta_s = sync2_reg[3];
  wire tb_s = sync2_reg[2];
  wire vpp_s = sync2_reg[1];
  wire burn_s = sync2_reg[0];
  wire init_fall = prev_reg[7] & ~init_hv_s;
  wire init_rise = ~prev_reg[7] & init_hv_s;
  wire step_rise = ~prev_reg[6] & step_s;
  wire sclk_rise = ~prev_reg[5] & sclk_s;
  wire burn_fall = prev_reg[0] & ~burn_s;
  wire burn_rise = ~prev_reg[0] & burn_s;

  // Programming-mode latch and the entry arming flag.
  logic prog_reg;
  logic armed_reg;
  // Input and output shift registers.
  logic [W-1:0] in_reg;
  logic [W-1:0] out_reg;
  // Current location.
  logic [AW-1:0] addr_reg;
  // Burn in progress and protection candidate for it.
  logic burning_reg;
  logic cand_reg;
  logic protect_reg;
  logic [W-1:0] last_reg;
  otpp_pkg::otpp_stress_t stress_reg;
  otpp_pkg::otpp_stress_t stress_next;
  // The storage array; an unwritten location reads all ones.
  logic [W-1:0] mem [DEPTH];

  // Clock steering: high voltage feeds the input register, logic low
  // the output register, so one clock never shifts both.
  wire shift_in_en = prog_reg & sclk_rise & vpp_s & burn_s;
  wire load_en = prog_reg & sclk_rise & ~vpp_s & ~burn_s;
  wire shift_out_en = prog_reg & sclk_rise & ~vpp_s & burn_s;
  wire burn_start = prog_reg & vpp_s & burn_fall;
  wire burn_end = burn_rise & burning_reg & vpp_s;
  wire all_ones = &in_reg;
  wire all_zeros = ~|in_reg;
  // A burn can only clear bits, so writing all ones keeps old data.
  wire [W-1:0] burn_data = mem[addr_reg] & in_reg;
  // Protected read-back loads zeros instead of stored data.
  wire [W-1:0] load_data = protect_reg ? '0 : mem[addr_reg];

  // Stress decode, taken at the strobe that starts the operation.
  always_comb
  begin
    stress_next = stress_reg;
    if (prog_reg && burn_fall)
    begin
      stress_next = otpp_pkg::STRESS_NONE;
      if (vpp_s && ta_s && !tb_s && all_ones)
        stress_next = otpp_pkg::STRESS_WORDLINE;
      else if (vpp_s && ta_s && tb_s && all_ones)
        stress_next = otpp_pkg::STRESS_BITLINE;
      else if (!vpp_s && ta_s && tb_s && all_zeros)
        stress_next = otpp_pkg::STRESS_ERASE;
    end
  end

  // Entry: select low, init leaves high voltage and comes back.
  // The latch only clears with reset, as power-down would.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prog_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else if (!prog_reg)
    begin
      if (sel_s)
        armed_reg <= 1'b0;
      else if (init_fall)
        armed_reg <= 1'b1;
      else if (init_rise && armed_reg)
        prog_reg <= 1'b1;
    end
  end

  // Serial input register, MSB first; held until new data arrives.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      in_reg <= '0;
    else if (shift_in_en)
      in_reg <= {in_reg[W-2:0], sin_s};
  end

  // Output register: loaded by the read strobe, shifted by the clock.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      out_reg <= '0;
    else if (load_en)
      out_reg <= load_data;
    else if (shift_out_en)
      out_reg <= {out_reg[W-2:0], 1'b0};
  end

  // Address advances on each step strobe and wraps at the top.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addr_reg <= '0;
    else if (prog_reg && step_rise)
      addr_reg <= addr_reg + 1'b1;
  end

  // Burn tracking. The input must stay high for the whole pulse to
  // protect; a drop anywhere inside it cancels the candidate.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      burning_reg <= 1'b0;
      cand_reg <= 1'b0;
    end
    else if (burn_start)
    begin
      burning_reg <= 1'b1;
      cand_reg <= sin_s;
    end
    else if (!vpp_s || burn_end)
      burning_reg <= 1'b0;
    else if (burning_reg && !sin_s)
      cand_reg <= 1'b0;
  end

  // Protection is one-time: once set, only reset clears it, and later
  // burns at any address still write.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      protect_reg <= 1'b0;
    else if (burn_end && cand_reg)
      protect_reg <= 1'b1;
  end

  // Storage write at the end of a complete burn pulse.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= `OTPP_ERASED;
      last_reg <= '0;
    end
    else if (burn_end)
    begin
      mem[addr_reg] <= burn_data;
      last_reg <= burn_data;
    end
  end

  // Stress state follows its decode.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stress_reg <= otpp_pkg::STRESS_NONE;
    else
      stress_reg <= stress_next;
  end

  // Output pin enable: driven only in programming mode.
  logic oe_reg;
  logic so_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oe_reg <= 1'b0;
      so_reg <= 1'b0;
    end
    else
    begin
      oe_reg <= prog_reg;
      so_reg <= out_reg[W-1];
    end
  end

  assign link.serial_out_o = so_reg;
  assign link.serial_out_oe = oe_reg;
  assign prog_mode = prog_reg;
  assign read_protected = protect_reg;
  assign address = addr_reg;
  assign last_burn = last_reg;
  assign stress_mode = stress_reg;
endmodule : otpp_device

// ===== rtl/otpp_if.sv
`timescale 1ns/1ps
interface otpp_if;
  // Pins driven by the programmer.
  logic prog_select_pin;
  logic init_hv_pin;
  logic address_step_pin;
  logic serial_clock_pin;
  logic serial_in_pin;
  logic test_decode_a;
  logic test_decode_b;
  logic program_voltage_pin;
  logic burn_strobe_pin;
  // Serial output of the device as output and enable.
  logic serial_out_o;
  logic serial_out_oe;
  // Resolved level; an undriven pin reads low here.
  wire serial_out_pin = serial_out_oe & serial_out_o;
  modport dev (
    input prog_select_pin, init_hv_pin, address_step_pin,
    input serial_clock_pin, serial_in_pin, test_decode_a,
    input test_decode_b, program_voltage_pin, burn_strobe_pin,
    output serial_out_o, serial_out_oe
  );
  modport prg (
    output prog_select_pin, init_hv_pin, address_step_pin,
    output serial_clock_pin, serial_in_pin, test_decode_a,
    output test_decode_b, program_voltage_pin, burn_strobe_pin,
    input serial_out_pin
  );
endinterface : otpp_if

// ===== rtl/otpp_pkg.sv
`include "otpp_cfg.svh"
package otpp_pkg;
  // Stress test selected by the most recent burn or load strobe.
  typedef enum logic [1:0] {
    STRESS_NONE,
    STRESS_WORDLINE,
    STRESS_BITLINE,
    STRESS_ERASE
  } otpp_stress_t;
  // Programmer sequencer states.
  typedef enum logic [4:0] {
    ST_ENTRY0, ST_ENTRY1, ST_ENTRY2, ST_IDLE,
    ST_SH_LO, ST_SH_HI, ST_PRE_BURN, ST_BURN, ST_POST_BURN,
    ST_VLOW, ST_LD_LO, ST_LD_HI, ST_LD_END,
    ST_RD_LO, ST_RD_HI, ST_STEP_HI, ST_STEP_LO, ST_DONE
  } otpp_state_t;
endpackage : otpp_pkg

// ===== rtl/otpp_programmer.sv
`timescale 1ns/1ps
`include "otpp_cfg.svh"
// Byte queue with registered full and empty indications.
module otpp_fifo #(
  parameter int WIDTH = `OTPP_BYTE_W,
  parameter int DEPTH = `OTPP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic ready_reg;
  logic valid_reg;
  wire push = in_valid & ready_reg;
  wire pop = out_ready & valid_reg;
  wire [AW:0] cnt_next = cnt_reg + {{AW{1'b0}}, push} -
                         {{AW{1'b0}}, pop};
  // Pointers, count and flags; flags track the next count.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= push ? wr_reg + 1'b1 : wr_reg;
      rd_reg <= pop ? rd_reg + 1'b1 : rd_reg;
      cnt_reg <= cnt_next;
      ready_reg <= cnt_next != (AW + 1)'(DEPTH);
      valid_reg <= cnt_next != '0;
    end
  end
  // Storage write; no reset needed on the data.
  always_ff @(posedge clk)
  begin
    if (push)
      store[wr_reg] <= in_data;
  end
  assign in_ready = ready_reg;
  assign out_valid = valid_reg;
  assign out_data = store[rd_reg];
endmodule : otpp_fifo

// Programmer end: enters programming, then burns, verifies and steps
// for each queued byte. The serial clock is made here by a divider.
module otpp_programmer #(
  parameter int HALF = `OTPP_HALF,
  parameter int BURN_CYC = `OTPP_BURN_US * `OTPP_CLK_MHZ
) (
  input wire logic clk,
  input wire logic arst_n,
  otpp_if.prg link,
  input wire logic wr_valid,
  input wire logic [`OTPP_BYTE_W-1:0] wr_data,
  output logic wr_ready,
  input wire logic protect_req,
  input wire logic test_a,
  input wire logic test_b,
  output logic [`OTPP_BYTE_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy
);
  localparam int W = `OTPP_BYTE_W;
  otpp_pkg::otpp_state_t st_reg;
  logic [31:0] tmr_reg;
  logic [3:0] bit_reg;
  logic [W-1:0] sh_reg;
  logic [W-1:0] rd_reg;
  logic rdv_reg;
  // Busy flag kept in step with the state, so the output is a register.
  logic busy_reg;
  logic q_valid;
  logic [W-1:0] q_data;
  logic so1_reg;
  logic so2_reg;
  logic sel_reg, init_reg, step_reg, sclk_reg, sin_reg;
  logic vpp_reg, burn_reg, ta_reg, tb_reg;
  wire tick = tmr_reg == '0;
  wire last_bit = bit_reg == 4'(W - 1);
  wire take = (st_reg == otpp_pkg::ST_IDLE) & q_valid;

  otpp_fifo #(.WIDTH(W), .DEPTH(`OTPP_FIFO_DEPTH)) u_fifo (
    .clk(clk), .arst_n(arst_n), .in_valid(wr_valid),
    .in_data(wr_data), .in_ready(wr_ready), .out_valid(q_valid),
    .out_data(q_data), .out_ready(take));

  // Read-back pin comes from the device domain.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      so1_reg <= 1'b0;
      so2_reg <= 1'b0;
    end
    else
    begin
      so1_reg <= link.serial_out_pin;
      so2_reg <= so1_reg;
    end
  end

  // Sequencer: each state but ST_IDLE lasts HALF cycles, the burn BURN_CYC.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= otpp_pkg::ST_ENTRY0;
      tmr_reg <= 32'(HALF - 1);
      bit_reg <= '0;
      sh_reg <= '0;
      rd_reg <= '0;
      rdv_reg <= 1'b0;
      busy_reg <= 1'b1;
      sel_reg <= 1'b0;
      init_reg <= 1'b1;
      step_reg <= 1'b0;
      sclk_reg <= 1'b0;
      sin_reg <= 1'b0;
      vpp_reg <= 1'b1;
      burn_reg <= 1'b1;
      ta_reg <= 1'b0;
      tb_reg <= 1'b0;
    end
    else
    begin
      rdv_reg <= 1'b0;
      ta_reg <= test_a;
      tb_reg <= test_b;
      tmr_reg <= tick ? 32'(HALF - 1) : tmr_reg - 1'b1;
      case (st_reg)
        otpp_pkg::ST_ENTRY0: if (tick)
        begin
          init_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_ENTRY1;
        end
        otpp_pkg::ST_ENTRY1: if (tick)
        begin
          init_reg <= 1'b1;
          st_reg <= otpp_pkg::ST_ENTRY2;
        end
        otpp_pkg::ST_ENTRY2: if (tick)
        begin
          busy_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_IDLE;
        end
        otpp_pkg::ST_IDLE: if (take)
        begin
          busy_reg <= 1'b1;
          sh_reg <= q_data;
          bit_reg <= '0;
          st_reg <= otpp_pkg::ST_SH_LO;
          tmr_reg <= 32'(HALF - 1);
        end
        otpp_pkg::ST_SH_LO: if (tick)
        begin
          sclk_reg <= 1'b1;
          st_reg <= otpp_pkg::ST_SH_HI;
        end
        otpp_pkg::ST_SH_HI: if (tick)
        begin
          sclk_reg <= 1'b0;
          sh_reg <= {sh_reg[W-2:0], 1'b0};
          bit_reg <= bit_reg + 1'b1;
          st_reg <= last_bit ? otpp_pkg::ST_PRE_BURN
                             : otpp_pkg::ST_SH_LO;
        end
        otpp_pkg::ST_PRE_BURN: if (tick)
        begin
          burn_reg <= 1'b0;
          tmr_reg <= 32'(BURN_CYC - 1);
          st_reg <= otpp_pkg::ST_BURN;
        end
        otpp_pkg::ST_BURN: if (tick)
        begin
          burn_reg <= 1'b1;
          st_reg <= otpp_pkg::ST_POST_BURN;
        end
        otpp_pkg::ST_POST_BURN: if (tick)
        begin
          vpp_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_VLOW;
        end
        otpp_pkg::ST_VLOW: if (tick)
        begin
          burn_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_LD_LO;
        end
        otpp_pkg::ST_LD_LO: if (tick)
        begin
          sclk_reg <= 1'b1;
          st_reg <= otpp_pkg::ST_LD_HI;
        end
        otpp_pkg::ST_LD_HI: if (tick)
        begin
          sclk_reg <= 1'b0;
          burn_reg <= 1'b1;
          bit_reg <= '0;
          st_reg <= otpp_pkg::ST_LD_END;
        end
        otpp_pkg::ST_LD_END: if (tick)
          st_reg <= otpp_pkg::ST_RD_LO;
        otpp_pkg::ST_RD_LO: if (tick)
        begin
          rd_reg <= {rd_reg[W-2:0], so2_reg};
          sclk_reg <= 1'b1;
          st_reg <= otpp_pkg::ST_RD_HI;
        end
        otpp_pkg::ST_RD_HI: if (tick)
        begin
          sclk_reg <= 1'b0;
          bit_reg <= bit_reg + 1'b1;
          st_reg <= last_bit ? otpp_pkg::ST_STEP_HI
                             : otpp_pkg::ST_RD_LO;
          step_reg <= last_bit;
        end
        otpp_pkg::ST_STEP_HI: if (tick)
        begin
          step_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_STEP_LO;
        end
        otpp_pkg::ST_STEP_LO: if (tick)
        begin
          vpp_reg <= 1'b1;
          st_reg <= otpp_pkg::ST_DONE;
        end
        otpp_pkg::ST_DONE: if (tick)
        begin
          rdv_reg <= 1'b1;
          busy_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_IDLE;
        end
        default:
        begin
          busy_reg <= 1'b0;
          st_reg <= otpp_pkg::ST_IDLE;
        end
      endcase
      // Data line: each bit is set a half period before its clock rise,
      // so it moves with the clock fall, never with a rise; protection follows.
      if (take)
        sin_reg <= q_data[W-1];
      else if (st_reg == otpp_pkg::ST_SH_HI && tick)
        sin_reg <= last_bit ? protect_req : sh_reg[W-2];
      else if (st_reg == otpp_pkg::ST_BURN && tick)
        sin_reg <= 1'b0;
    end
  end

  assign link.prog_select_pin = sel_reg;
  assign link.init_hv_pin = init_reg;
  assign link.address_step_pin = step_reg;
  assign link.serial_clock_pin = sclk_reg;
  assign link.serial_in_pin = sin_reg;
  assign link.test_decode_a = ta_reg;
  assign link.test_decode_b = tb_reg;
  assign link.program_voltage_pin = vpp_reg;
  assign link.burn_strobe_pin = burn_reg;
  assign rd_data = rd_reg;
  assign rd_valid = rdv_reg;
  assign busy = busy_reg;
endmodule : otpp_programmer

// ===== test/otp_eprom_program_port_test.sv
`timescale 1ns/1ps
`include "otpp_cfg.svh"
module otp_eprom_program_port_test;
  // Short burn keeps the run brief; HALF leaves margin for the queue fill.
  localparam int HALF = 8;
  localparam int BURN_CYC = 40;
  logic clk, arst_n, wr_valid, wr_ready, protect_req, test_a, test_b;
  logic rd_valid, busy, prog_mode, read_protected, b_prog_mode;
  logic [7:0] wr_data, rd_data, address, last_burn, b_address, b_last_burn;
  otpp_pkg::otpp_stress_t stress_mode, se;
  // Pins of the second link: sel,init,step,sclk,sin,ta,tb,vpp,burn.
  logic [8:0] pv;
  logic [7:0] d;
  int num_errors, total_checks, seed, addr, n;
  int mem[256];
  bit prot;
  logic [7:0] q_data[$];
  bit q_prot[$];

  otpp_if l1();
  otpp_if l2();
  assign {l2.prog_select_pin, l2.init_hv_pin, l2.address_step_pin,
    l2.serial_clock_pin, l2.serial_in_pin, l2.test_decode_a,
    l2.test_decode_b, l2.program_voltage_pin, l2.burn_strobe_pin} = pv;

  otpp_programmer #(.HALF(HALF), .BURN_CYC(BURN_CYC)) i_otpp_programmer (
    .clk(clk), .arst_n(arst_n), .link(l1.prg), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .protect_req(protect_req),
    .test_a(test_a), .test_b(test_b), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy));
  otpp_device i_otpp_device (.clk(clk), .arst_n(arst_n), .link(l1.dev),
    .prog_mode(prog_mode), .read_protected(read_protected),
    .address(address), .last_burn(last_burn), .stress_mode(stress_mode));
  // Second device faces the bench, which breaks the link rules on purpose.
  otpp_device i_otpp_device_b (.clk(clk), .arst_n(arst_n),
    .link(l2.dev), .prog_mode(b_prog_mode), .read_protected(),
    .address(b_address), .last_burn(b_last_burn), .stress_mode());
  otpp_link_assertions #(.BURN_CYC(BURN_CYC)) i_otpp_link_assertions (
    .clk(clk), .arst_n(arst_n), .prog_select_pin(l1.prog_select_pin),
    .init_hv_pin(l1.init_hv_pin), .address_step_pin(l1.address_step_pin),
    .serial_clock_pin(l1.serial_clock_pin),
    .serial_in_pin(l1.serial_in_pin), .test_decode_a(l1.test_decode_a),
    .test_decode_b(l1.test_decode_b),
    .program_voltage_pin(l1.program_voltage_pin),
    .burn_strobe_pin(l1.burn_strobe_pin), .serial_out_o(l1.serial_out_o),
    .serial_out_oe(l1.serial_out_oe));

  // Clock of 5 ns.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task check(input string name, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : check

  // Prints the verdict and stops.
  task finish_test;
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Sets the second link's pins and holds them for HALF cycles.
  task put(input logic [8:0] v);
    @(posedge clk);
    #1 pv = v;
    repeat (HALF - 1) @(posedge clk);
  endtask : put

  // Offers one byte and holds it until the queue takes it.
  task push(input logic [7:0] b, input bit p);
    @(posedge clk);
    #1 wr_valid = 1'b1;
    wr_data = b;
    repeat (1000)
    begin
      @(posedge clk);
      if (wr_ready === 1'b1)
        break;
    end
    check("queue ready", 8'h01, {7'h00, wr_ready});
    q_data.push_back(b);
    q_prot.push_back(p);
    #1 wr_valid = 1'b0;
  endtask : push

  // Waits, bounded, until every queued byte has come back.
  task wait_idle;
    repeat (20000)
    begin
      @(posedge clk);
      #1;
      if (q_data.size() == 0 && busy === 1'b0)
        break;
    end
    check("queue drained", 8'h00, 8'(q_data.size()));
    check("busy", 8'h00, {7'h00, busy});
  endtask : wait_idle

  // Reference model of the array, run at every returned byte.
  always @(negedge clk)
    if (rd_valid === 1'b1)
    begin
      prot = prot | q_prot.pop_front();
      mem[addr] = mem[addr] & q_data.pop_front();
      check("read data", prot ? 8'h00 : 8'(mem[addr]), rd_data);
      check("burned", 8'(mem[addr]), last_burn);
      addr = (addr + 1) % 256;
      check("address", 8'(addr), address);
      check("protect", {7'h00, prot}, {7'h00, read_protected});
    end

  // Stress decode at each strobe; only cases with a defined outcome count.
  always @(negedge l1.burn_strobe_pin)
    if (arst_n === 1'b1 && q_data.size() > 0)
    begin
      d = q_data[0];
      if (l1.program_voltage_pin && l1.test_decode_a && d == 8'hff)
        se = l1.test_decode_b ? otpp_pkg::STRESS_BITLINE :
          otpp_pkg::STRESS_WORDLINE;
      else if (l1.test_decode_a && l1.test_decode_b && d == 8'h00)
        se = otpp_pkg::STRESS_ERASE;
      else
        se = otpp_pkg::STRESS_NONE;
      repeat (8) @(negedge clk);
      if (!(l1.test_decode_a | l1.test_decode_b) ||
          d == (l1.program_voltage_pin ? 8'hff : 8'h00))
        check("stress", {6'h00, se}, {6'h00, stress_mode});
    end

  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    seed = 95;
    {wr_valid, wr_data, protect_req, test_a, test_b, prot, addr} = '0;
    pv = 9'h083;
    foreach (mem[i])
      mem[i] = 255;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    check("mode at reset", 8'h00, {7'h00, prog_mode});
    // Fill the queue while the programmer is still entering.
    @(posedge clk);
    #1 wr_valid = 1'b1;
    n = 0;
    while (n < 20)
    begin
      wr_data = 8'($random(seed));
      @(posedge clk);
      if (wr_ready !== 1'b1)
        break;
      q_data.push_back(wr_data);
      q_prot.push_back(1'b0);
      n++;
      #1;
    end
    #1 wr_valid = 1'b0;
    check("queue depth", 8'h10, 8'(n));
    // Second link: a burn before entry must be ignored.
    put(9'h082);
    put(9'h083);
    check("mode early", 8'h00, {7'h00, b_prog_mode});
    put(9'h003);
    put(9'h083);
    check("mode entered", 8'h01, {7'h00, b_prog_mode});
    for (int i = 7; i >= 0; i--)
    begin
      put(9'h083 | (9'(8'h5a >> i & 8'h01) << 4));
      put(9'h0a3 | (9'(8'h5a >> i & 8'h01) << 4));
    end
    // Voltage dropped in mid burn aborts the write.
    put(9'h082);
    put(9'h080);
    put(9'h081);
    check("aborted burn", 8'h00, b_last_burn);
    put(9'h083);
    put(9'h082);
    put(9'h083);
    check("kept byte", 8'h5a, b_last_burn);
    put(9'h081);
    put(9'h080);
    put(9'h0a0);
    put(9'h081);
    for (int i = 7; i >= 0; i--)
    begin
      check("read bit", 8'(8'h5a >> i & 8'h01), 8'(l2.serial_out_pin));
      put(9'h0a1);
      put(9'h081);
    end
    put(9'h0c1);
    put(9'h081);
    check("step", 8'h01, b_address);
    wait_idle();
    // Each stress mode once, then protection added by an all-ones burn.
    for (int m = 0; m < 3; m++)
    begin
      test_a = 1'b1;
      test_b = (m > 0);
      push(m == 2 ? 8'h00 : 8'hff, 1'b0);
      wait_idle();
    end
    {test_a, test_b} = 2'b00;
    protect_req = 1'b1;
    push(8'hff, 1'b1);
    wait_idle();
    protect_req = 1'b0;
    push(8'h3c, 1'b0);
    push(8'($random(seed)), 1'b0);
    wait_idle();
    finish_test();
  end
endmodule : otp_eprom_program_port_test

// ===== test/otpp_link_assertions.sv
`timescale 1ns/1ps
// Watches the programming link between the two ends.
module otpp_link_assertions #(
  parameter int BURN_CYC = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic prog_select_pin,
  input wire logic init_hv_pin,
  input wire logic address_step_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic test_decode_a,
  input wire logic test_decode_b,
  input wire logic program_voltage_pin,
  input wire logic burn_strobe_pin,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  // Cycles since the last read-side clock rise, saturating at 15.
  logic [3:0] rd_age_reg;
  // Cycles the burn strobe has been low.
  logic [15:0] burn_len_reg;
  // Set once init was seen rising with select low.
  logic entry_seen_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // The read-age helper starts saturated so an output move right after reset is caught.
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rd_age_reg <= 4'hf;
      burn_len_reg <= 16'h0000;
      entry_seen_reg <= 1'b0;
    end
    else
    begin
      rd_age_reg <= ($rose(serial_clock_pin) && !program_voltage_pin) ?
        4'h0 : rd_age_reg + {3'h0, rd_age_reg != 4'hf};
      burn_len_reg <= burn_strobe_pin ? 16'h0000 : burn_len_reg + 16'h0001;
      entry_seen_reg <= entry_seen_reg |
        ($rose(init_hv_pin) & !prog_select_pin);
    end

  a_entry_select: assert property ($fell(init_hv_pin) |->
    (!prog_select_pin && !init_hv_pin)[*4]) else $error("bad entry");
  a_entry_sets_mode: assert property (
    $rose(init_hv_pin) && !prog_select_pin |-> ##[2:10] serial_out_oe)
    else $error("entry not taken");
  a_oe_needs_entry: assert property (serial_out_oe |-> entry_seen_reg)
    else $error("output driven before entry");
  a_shift_strobe_high: assert property (
    $rose(serial_clock_pin) && program_voltage_pin |->
    burn_strobe_pin && $stable(serial_in_pin)) else $error("shift unsafe");
  a_burn_length: assert property (
    $rose(burn_strobe_pin) && program_voltage_pin |->
    burn_len_reg >= BURN_CYC && burn_len_reg <= BURN_CYC + 1)
    else $error("burn pulse length wrong");
  a_vpp_after_burn: assert property (
    $rose(burn_strobe_pin) && program_voltage_pin |->
    ##[1:20] !program_voltage_pin) else $error("no read-back mode");
  a_load_clocked: assert property (
    $fell(burn_strobe_pin) && !program_voltage_pin |->
    ##[2:20] (serial_clock_pin && !burn_strobe_pin))
    else $error("load strobe without clock");
  a_out_on_clock: assert property (
    $changed(serial_out_o) && serial_out_oe |-> rd_age_reg < 4'h9)
    else $error("output moved without read clock");
  a_step_shape: assert property ($rose(address_step_pin) |->
    (address_step_pin && !serial_clock_pin && burn_strobe_pin)[*4])
    else $error("step strobe malformed");
  a_protect_hold: assert property (
    $fell(burn_strobe_pin) && program_voltage_pin |=>
    ($stable(serial_in_pin) until burn_strobe_pin))
    else $error("serial input moved in burn");

  c_burn: cover property ($fell(burn_strobe_pin) && program_voltage_pin);
  c_load: cover property ($fell(burn_strobe_pin) && !program_voltage_pin);
  c_step: cover property ($rose(address_step_pin));
endmodule : otpp_link_assertions
